// ==== hw/caccw_top.v ====
`timescale 1ns/10ps
// Summary of operation
// - Each module picks its own mode from its mode register bits.
// - Qualifying line edge in capture mode copies counter into compare pair.
// - Capture or match sets event flag; irq needs local and both global enables.
// - Capture line level counts only after two stable clocks.
// - Software timer: 16-bit counter equals compare pair sets event flag.
// - Low byte write clears comparator enable; high byte write sets it.
// - High-speed output toggles the line on each 16-bit match.
// - Frequency output toggles on low-byte match, adds high byte to low byte.
// - Frequency output needs comparator, toggle and pwm enables all set.
// - 8-bit PWM: high on low-byte match, low on low-byte overflow.
// - 8-bit PWM reloads compare low byte from high byte on rollover.
// - PWM with comparator enable clear holds output low.
// - 16-bit PWM: high on full match, low on counter overflow.
// - Watchdog enable makes module 2 a watchdog comparing high bytes.
// - Watchdog is enabled after every reset.
// - Watchdog forces counter running; run bit reads only software value.
// - Watchdog blocks counter writes, freezes timebase, idle, module 2 mode.
// - Module 2 high byte matching counter high byte causes system reset.
// - With watchdog on, any write to module 2 high byte reloads it with counter high plus its low byte.
// - Watchdog reset fires when counter low byte overflows during that match.
// - Writing one to module 2 flag with watchdog on forces reset.
`include "caccw_defs.vh"
module caccw_top #(
   parameter NUM_MOD = 3
) (
   input  wire                 clk,
   input  wire                 sys_rst,
   input  wire                 hsel,
   input  wire [31:0]          haddr,
   input  wire [1:0]           htrans,
   input  wire                 hwrite,
   input  wire [2:0]           hsize,
   input  wire [31:0]          hwdata,
   input  wire                 hready,
   output reg  [31:0]          hrdata,
   output reg                  hreadyout,
   output reg                  hresp,
   input  wire [15:0]          cntValue,
   input  wire                 cntAdvance,
   input  wire                 globalIrqEnable,
   input  wire                 arrayIrqGroupEnable,
   input  wire [NUM_MOD-1:0]   moduleIoIn,
   output reg  [NUM_MOD-1:0]   moduleIoOut,
   output reg  [NUM_MOD-1:0]   moduleIoOe,
   output reg                  counterRunOut,
   output reg  [2:0]           timebaseSelect,
   output reg                  idleSuspend,
   output reg                  cntLoadLow,
   output reg                  cntLoadHigh,
   output reg  [7:0]           cntLoadData,
   output reg                  moduleIrq,
   output reg                  watchdogResetReq
);

   // Bus data-phase capture
   reg         wrPend_reg;
   reg  [7:0]  wrAddr_reg;
   // Counter mode register pieces
   reg         watchdogEnable_reg;
   reg         counterRun_reg;
   // Reset image of the counter mode register
   localparam [7:0] CTRL_RST = `CACCW_CTRL_RESET;
   reg  [31:0] rdNext;
   wire [7:0]  wrData = hwdata[7:0];
   wire        addrPhase = hsel & htrans[1] & hready;
   wire        ctrlWr = wrPend_reg & (wrAddr_reg == `CACCW_CTRL_ADDR);
   wire        flagWr = wrPend_reg & (wrAddr_reg == `CACCW_FLAGS_ADDR);
   // Counter low byte wraps when the advanced value reads zero
   wire        lowWrap = cntAdvance & (cntValue[7:0] == `CACCW_LOW_WRAP);
   // Post-advance value used, so no history flop is needed for overflow
   wire        fullWrap = cntAdvance & (cntValue == 16'h0000);
   wire [8*NUM_MOD-1:0] modeAll;
   wire [8*NUM_MOD-1:0] cmpLAll;
   wire [8*NUM_MOD-1:0] cmpHAll;
   wire [NUM_MOD-1:0]   flagAll;
   wire [NUM_MOD-1:0]   eccfAll;

   // AHB-Lite: zero wait states, always OKAY, reads registered at address phase
   // Read data holds until the next read address phase
   always @(posedge clk) begin
      if (sys_rst) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         hrdata     <= 32'h00000000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end else begin
         wrPend_reg <= addrPhase & hwrite;
         wrAddr_reg <= haddr[7:0];
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         if (addrPhase & ~hwrite) begin
            hrdata <= rdNext;
         end
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin : rdMux
      integer k;
      k = 0;
      rdNext = 32'h00000000;
      case (haddr[7:0])
         `CACCW_CTRL_ADDR: begin
            rdNext[7:0] = {2'b00, idleSuspend, timebaseSelect, counterRun_reg, watchdogEnable_reg};
         end
         `CACCW_FLAGS_ADDR: rdNext[NUM_MOD-1:0] = flagAll;
         `CACCW_CNTLO_ADDR: rdNext[7:0] = cntValue[7:0];
         `CACCW_CNTHI_ADDR: rdNext[7:0] = cntValue[15:8];
         default: begin
            // Loop decode lets NUM_MOD grow without new case items
            for (k = 0; k < NUM_MOD; k = k + 1) begin
               if (haddr[7:0] == (`CACCW_MOD_BASE + `CACCW_MOD_STRIDE * k + `CACCW_MODE_OFS))
                  rdNext[7:0] = modeAll[8*k +: 8];
               if (haddr[7:0] == (`CACCW_MOD_BASE + `CACCW_MOD_STRIDE * k + `CACCW_CMPL_OFS))
                  rdNext[7:0] = cmpLAll[8*k +: 8];
               if (haddr[7:0] == (`CACCW_MOD_BASE + `CACCW_MOD_STRIDE * k + `CACCW_CMPH_OFS))
                  rdNext[7:0] = cmpHAll[8*k +: 8];
            end
         end
      endcase
   end

   // Counter mode register and counter-facing controls
   always @(posedge clk) begin
      if (sys_rst) begin
         watchdogEnable_reg <= CTRL_RST[`CACCW_CTRL_WDT];
         counterRun_reg     <= 1'b0;
         timebaseSelect     <= 3'h0;
         idleSuspend        <= 1'b0;
         counterRunOut      <= 1'b1;
         cntLoadLow         <= 1'b0;
         cntLoadHigh        <= 1'b0;
         cntLoadData        <= 8'h00;
      end else begin
         if (ctrlWr) begin
            watchdogEnable_reg <= wrData[`CACCW_CTRL_WDT];
            counterRun_reg     <= wrData[`CACCW_CTRL_RUN];
            // The write that clears the watchdog bit still meets frozen bits
            // timebase and idle frozen
            if (!watchdogEnable_reg) begin
               timebaseSelect <= wrData[`CACCW_CTRL_TB_LSB +: 3];
               idleSuspend    <= wrData[`CACCW_CTRL_IDLE];
            end
         end
         counterRunOut <= watchdogEnable_reg | counterRun_reg;
         cntLoadLow  <= wrPend_reg & ~watchdogEnable_reg & (wrAddr_reg == `CACCW_CNTLO_ADDR);
         cntLoadHigh <= wrPend_reg & ~watchdogEnable_reg & (wrAddr_reg == `CACCW_CNTHI_ADDR);
         cntLoadData <= wrData;
      end
   end

   // Watchdog reset and interrupt output
   // One pulse per cause; system reset logic stretches it if it must
   always @(posedge clk) begin
      if (sys_rst) begin
         watchdogResetReq <= 1'b0;
         moduleIrq        <= 1'b0;
      end else begin
         // high-byte match at low wrap; forced by flag write
         watchdogResetReq <= watchdogEnable_reg &
            ((lowWrap & (cmpHAll[8*`CACCW_WDT_MOD +: 8] == cntValue[15:8])) |
             (flagWr & wrData[`CACCW_WDT_MOD]));
         moduleIrq <= globalIrqEnable & arrayIrqGroupEnable & |(flagAll & eccfAll);
      end
   end

   genvar i;
   generate
      for (i = 0; i < NUM_MOD; i = i + 1) begin : gMod
         localparam integer BASE = `CACCW_MOD_BASE + `CACCW_MOD_STRIDE * i;
         localparam         IS_WDT = (i == `CACCW_WDT_MOD);
         reg  [7:0] mode_reg;
         reg  [7:0] cmpL_reg;
         reg  [7:0] cmpH_reg;
         reg        flag_reg;
         reg        sync1_reg;
         reg        sync2_reg;
         reg        hist_reg;
         reg        level_reg;
         wire       wdtOwn = IS_WDT & watchdogEnable_reg;
         wire       modeWr = wrPend_reg & (wrAddr_reg == BASE[7:0] + `CACCW_MODE_OFS);
         wire       cmpLWr = wrPend_reg & (wrAddr_reg == BASE[7:0] + `CACCW_CMPL_OFS);
         wire       cmpHWr = wrPend_reg & (wrAddr_reg == BASE[7:0] + `CACCW_CMPH_OFS);
         wire ecom  = mode_reg[`CACCW_M_ECOM];
         wire pwmEn = mode_reg[`CACCW_M_PWM];
         wire tog   = mode_reg[`CACCW_M_TOG];
         wire mat   = mode_reg[`CACCW_M_MAT];
         wire capP  = mode_reg[`CACCW_M_CAPP];
         wire capN  = mode_reg[`CACCW_M_CAPN];
         wire capMode  = (capP | capN) & ~mat & ~tog & ~pwmEn;
         wire freqMode = ecom & tog & pwmEn;
         wire pwm8     = ecom & pwmEn & ~tog & ~mode_reg[`CACCW_M_PWM16];
         wire pwm16    = ecom & pwmEn & ~tog & mode_reg[`CACCW_M_PWM16];
         wire hsoMode  = ecom & mat & tog & ~pwmEn;
         // Matching every clock would repeat events on a slow timebase
         // compares only on the advance strobe
         wire match16  = cntAdvance & (cntValue == {cmpH_reg, cmpL_reg});
         wire matchLow = cntAdvance & (cntValue[7:0] == cmpL_reg);
         // level accepted after two equal synchronised samples
         wire stable   = (sync2_reg == hist_reg);
         wire rise     = stable & sync2_reg & ~level_reg;
         wire fall     = stable & ~sync2_reg & level_reg;
         wire capEvt   = capMode & ((capP & rise) | (capN & fall)) & ~wdtOwn;
         // timer match, suppressed while serving as watchdog
         wire cmpEvt   = ecom & mat & match16 & ~pwmEn & ~wdtOwn;
         wire pwmEvt   = mat & (pwm16 ? match16 : (pwm8 & matchLow));

         assign modeAll[8*i +: 8] = mode_reg;
         assign cmpLAll[8*i +: 8] = cmpL_reg;
         assign cmpHAll[8*i +: 8] = cmpH_reg;
         assign flagAll[i]        = flag_reg;
         assign eccfAll[i]        = mode_reg[`CACCW_M_ECCF];

         // Input synchroniser and two-cycle filter
         // Costs about four clocks of capture latency; shorter glitches never count
         always @(posedge clk) begin
            if (sys_rst) begin
               sync1_reg <= 1'b0;
               sync2_reg <= 1'b0;
               hist_reg  <= 1'b0;
               level_reg <= 1'b0;
            end else begin
               sync1_reg <= moduleIoIn[i];
               sync2_reg <= sync1_reg;
               hist_reg  <= sync2_reg;
               if (stable) begin
                  level_reg <= sync2_reg;
               end
            end
         end

         // Mode register; module 2 locked into timer mode by the watchdog
         // Mode writes to module 2 are lost, not queued, while the watchdog runs
         always @(posedge clk) begin
            if (sys_rst) begin
               mode_reg <= `CACCW_MODE_RESET;
            end else if (wdtOwn) begin
               mode_reg <= (8'h01 << `CACCW_M_ECOM) | (8'h01 << `CACCW_M_MAT);
            end else if (modeWr) begin
               mode_reg <= wrData;
            end else if (cmpLWr) begin
               mode_reg <= mode_reg & ~(8'h01 << `CACCW_M_ECOM);
            end else if (cmpHWr) begin
               mode_reg <= mode_reg | (8'h01 << `CACCW_M_ECOM);
            end
         end

         // Compare pair: hardware updates win over software writes
         // Frequency step and 8-bit reload never meet; their modes exclude each other
         always @(posedge clk) begin
            if (sys_rst) begin
               cmpL_reg <= `CACCW_CMP_RESET;
               cmpH_reg <= `CACCW_CMP_RESET;
            end else if (capEvt) begin
               cmpL_reg <= cntValue[7:0];
               cmpH_reg <= cntValue[15:8];
            end else begin
               if (freqMode & matchLow) begin
                  cmpL_reg <= cmpL_reg + cmpH_reg;
               end else if (pwm8 & lowWrap) begin
                  cmpL_reg <= cmpH_reg;
               end else if (cmpLWr) begin
                  cmpL_reg <= wrData;
               end
               if (cmpHWr) begin
                  cmpH_reg <= wdtOwn ? (cntValue[15:8] + cmpL_reg) : wrData;
               end
            end
         end

         // Event flag: set wins over a software clear in the same cycle
         // Otherwise a clear racing a capture would lose the event
         always @(posedge clk) begin
            if (sys_rst) begin
               flag_reg <= 1'b0;
            end else if (capEvt | cmpEvt | pwmEvt | (hsoMode & match16 & ~wdtOwn)) begin
               flag_reg <= 1'b1;
            end else if (flagWr) begin
               flag_reg <= wrData[i];
            end
         end

         // Output line; pin driven only in output-producing modes
         // Enable registered too, so pin and level turn over on one edge
         always @(posedge clk) begin
            if (sys_rst) begin
               moduleIoOut[i] <= 1'b0;
               moduleIoOe[i]  <= 1'b0;
            end else begin
               moduleIoOe[i] <= ~wdtOwn & ((ecom & tog) | pwmEn);
               if (pwmEn & ~ecom) begin
                  moduleIoOut[i] <= 1'b0;
               end else if (freqMode & matchLow) begin
                  moduleIoOut[i] <= ~moduleIoOut[i];
               end else if (hsoMode & match16 & ~wdtOwn) begin
                  moduleIoOut[i] <= ~moduleIoOut[i];
               end else if (pwm8) begin
                  // set on low match, clear on low wrap
                  if (matchLow) begin
                     moduleIoOut[i] <= 1'b1;
                  end else if (lowWrap) begin
                     moduleIoOut[i] <= 1'b0;
                  end
               end else if (pwm16) begin
                  // set on full match, clear on overflow
                  if (match16) begin
                     moduleIoOut[i] <= 1'b1;
                  end else if (fullWrap) begin
                     moduleIoOut[i] <= 1'b0;
                  end
               end
            end
         end
      end
   endgenerate

endmodule

// ==== hw/caccw_defs.vh ====
`ifndef CACCW_DEFS_VH
`define CACCW_DEFS_VH
// Register byte addresses
`define CACCW_CTRL_ADDR    8'h00
`define CACCW_FLAGS_ADDR   8'h04
`define CACCW_CNTLO_ADDR   8'h08
`define CACCW_CNTHI_ADDR   8'h0c
`define CACCW_MOD_BASE     16
`define CACCW_MOD_STRIDE   16
`define CACCW_MODE_OFS     0
`define CACCW_CMPL_OFS     4
`define CACCW_CMPH_OFS     8
// Counter mode register fields
`define CACCW_CTRL_WDT     0
`define CACCW_CTRL_RUN     1
`define CACCW_CTRL_TB_LSB  2
`define CACCW_CTRL_IDLE    5
// Module mode register fields
`define CACCW_M_PWM16      7
`define CACCW_M_ECOM       6
`define CACCW_M_CAPP       5
`define CACCW_M_CAPN       4
`define CACCW_M_MAT        3
`define CACCW_M_TOG        2
`define CACCW_M_PWM        1
`define CACCW_M_ECCF       0
// Reset values
`define CACCW_CTRL_RESET   8'h01
`define CACCW_MODE_RESET   8'h00
`define CACCW_CMP_RESET    8'h00
// Watchdog module index and low-byte rollover value
`define CACCW_WDT_MOD      2
`define CACCW_LOW_WRAP     8'h00
`endif

// ==== tb/caccw_sva.sv ====
`timescale 1ns/10ps
`include "caccw_defs.vh"
module caccw_sva #(
   parameter NUM_MOD = 3
) (
   input wire               clk,
   input wire               sys_rst,
   input wire               hsel,
   input wire [31:0]        haddr,
   input wire [1:0]         htrans,
   input wire               hwrite,
   input wire [31:0]        hwdata,
   input wire               hready,
   input wire [15:0]        cntValue,
   input wire               cntAdvance,
   input wire               globalIrqEnable,
   input wire               arrayIrqGroupEnable,
   input wire [NUM_MOD-1:0] moduleIoOut,
   input wire               counterRunOut,
   input wire [2:0]         timebaseSelect,
   input wire               cntLoadLow,
   input wire [7:0]         cntLoadData,
   input wire               moduleIrq,
   input wire               watchdogResetReq
);
   reg       apWr;
   reg [7:0] apAddr;
   // Address phase kept so data-phase effects can be traced back
   always @(posedge clk) begin
      apWr   <= hsel & htrans[1] & hready & hwrite;
      apAddr <= haddr[7:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   irq_gate_a: assert property (moduleIrq |-> $past(globalIrqEnable && arrayIrqGroupEnable))
      else $error("irq raised without both global enables");
   irq_drop_a: assert property (!arrayIrqGroupEnable |=> !moduleIrq)
      else $error("irq stayed up with group enable low");
   out_rise_a: assert property (|(moduleIoOut & ~$past(moduleIoOut)) |-> $past(cntAdvance))
      else $error("output rose without counter advance");
   wdt_on_reset_a: assert property ($fell(sys_rst) |-> counterRunOut && !watchdogResetReq)
      else $error("watchdog not active after reset");
   wdt_cause_a: assert property (watchdogResetReq |-> $past(cntAdvance && cntValue[7:0] == 8'h00)
      || $past(apWr && apAddr == `CACCW_FLAGS_ADDR && hwdata[2]))
      else $error("watchdog reset without a cause");
   wdt_pulse_a: assert property (watchdogResetReq |=> !watchdogResetReq)
      else $error("watchdog reset longer than one cycle");
   tb_frozen_a: assert property ($changed(timebaseSelect) |->
      $past(apWr && apAddr == `CACCW_CTRL_ADDR) || $past(apWr && apAddr == `CACCW_CTRL_ADDR, 2))
      else $error("timebase changed without a mode write");
   load_data_a: assert property (cntLoadLow |->
      $past(apWr && apAddr == `CACCW_CNTLO_ADDR) && cntLoadData == $past(hwdata[7:0]))
      else $error("counter load pulse wrong");
   cover property (watchdogResetReq);
   cover property (cntLoadLow);
   cover property ($rose(moduleIrq));
   cover property (|moduleIoOut);
endmodule
bind caccw_top caccw_sva #(.NUM_MOD(NUM_MOD)) chk_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .cntValue(cntValue), .cntAdvance(cntAdvance), .globalIrqEnable(globalIrqEnable),
   .arrayIrqGroupEnable(arrayIrqGroupEnable), .moduleIoOut(moduleIoOut), .counterRunOut(counterRunOut),
   .timebaseSelect(timebaseSelect), .cntLoadLow(cntLoadLow), .cntLoadData(cntLoadData),
   .moduleIrq(moduleIrq), .watchdogResetReq(watchdogResetReq));

// ==== tb/caccw_line_model.sv ====
`timescale 1ns/10ps
module caccw_line_model (
   input  wire logic       clk,
   input  wire logic [2:0] lineCmd,
   input  wire logic [2:0] moduleIoOut,
   input  wire logic [2:0] moduleIoOe,
   output wire logic [2:0] lineLevel
);
   logic [2:0] extLevel = 3'h0;
   always @(posedge clk) extLevel <= lineCmd;
   // Driving module wins the wire; no pull, so free lines show the external level
   assign lineLevel = (moduleIoOe & moduleIoOut) | (~moduleIoOe & extLevel);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`include "caccw_defs.vh"
module tb;
   logic        clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, cntAdvance = 0;
   logic        globalIrqEnable = 0, arrayIrqGroupEnable = 0;
   logic        hreadyout, hresp, runOut, idleS, ldLo, ldHi, irq, wdtReq;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, x = 45, r, q;
   logic [1:0]  htrans = 0;
   logic [15:0] cntValue = 0;
   logic [2:0]  lineCmd = 0, lineLvl, ioOut, ioOe, tbSel;
   logic [7:0]  ldData;
   int          n_fail = 0, n_checks = 0, nWdt = 0, nLoad = 0, w;
   always #2.5 clk = ~clk;
   caccw_top #(.NUM_MOD(3)) dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cntValue(cntValue), .cntAdvance(cntAdvance),
      .globalIrqEnable(globalIrqEnable), .arrayIrqGroupEnable(arrayIrqGroupEnable), .moduleIoIn(lineLvl),
      .moduleIoOut(ioOut), .moduleIoOe(ioOe), .counterRunOut(runOut), .timebaseSelect(tbSel),
      .idleSuspend(idleS), .cntLoadLow(ldLo), .cntLoadHigh(ldHi), .cntLoadData(ldData),
      .moduleIrq(irq), .watchdogResetReq(wdtReq));
   caccw_line_model line_u (.clk(clk), .lineCmd(lineCmd), .moduleIoOut(ioOut), .moduleIoOe(ioOe),
      .lineLevel(lineLvl));
   // Pulses counted here so tasks need not catch them in their cycle
   always @(posedge clk) begin
      if (wdtReq === 1'b1) nWdt++;
      if (ldLo === 1'b1) nLoad++;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task tmo;
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test();
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   function logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function logic [7:0] ma(input int n, input int o);
      return 8'(`CACCW_MOD_BASE + `CACCW_MOD_STRIDE * n + o);
   endfunction
   task waitRdy;
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (hreadyout !== 1'b1 && w < 50);
      if (w >= 50) tmo();
   endtask
   // One single AHB transfer; read data taken at the data-phase edge
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      waitRdy();
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      q = hrdata;
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      xfer(0, a, 32'h0);
      chk(q, e);
   endtask
   // Counter advance strobe with the post-advance value
   task adv(input logic [15:0] v);
      @(posedge clk);
      cntValue <= v;
      cntAdvance <= 1;
      @(posedge clk);
      cntAdvance <= 0;
      @(posedge clk);
      #1;
   endtask
   initial begin
      #400000;
      tmo();
   end
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 0;
      rd(`CACCW_CTRL_ADDR, 32'h01);
      wr(ma(2, 0), 32'h00);
      rd(ma(2, 0), 32'h48);
      wr(`CACCW_CTRL_ADDR, 32'h1f);
      rd(`CACCW_CTRL_ADDR, 32'h03);
      chk(runOut, 1);
      wr(`CACCW_CNTLO_ADDR, 32'h5a);
      repeat (2) @(posedge clk);
      chk(nLoad, 0);
      $display("test lock done");
      cntValue <= 16'h1234;
      wr(ma(2, 4), 32'h02);
      wr(ma(2, 8), 32'h77);
      rd(ma(2, 8), 32'h14);
      adv(16'h1300);
      chk(nWdt, 0);
      adv(16'h1400);
      chk(nWdt, 1);
      wr(`CACCW_FLAGS_ADDR, 32'h04);
      repeat (2) @(posedge clk);
      chk(nWdt, 2);
      wr(`CACCW_FLAGS_ADDR, 32'h00);
      wr(`CACCW_CTRL_ADDR, 32'h10);
      rd(`CACCW_CTRL_ADDR, 32'h00);
      wr(`CACCW_CTRL_ADDR, 32'h10);
      rd(`CACCW_CTRL_ADDR, 32'h10);
      wr(ma(2, 0), 32'h00);
      rd(ma(2, 0), 32'h00);
      chk(tbSel, 32'h4);
      chk(runOut, 0);
      wr(`CACCW_CNTLO_ADDR, 32'ha5);
      repeat (2) @(posedge clk);
      chk(nLoad, 1);
      $display("test watchdog done");
      // Capture: a one-cycle glitch must be filtered, a held level taken
      globalIrqEnable <= 1;
      arrayIrqGroupEnable <= 1;
      r = rnd();
      cntValue <= r[15:0];
      wr(ma(0, 0), 32'h21);
      wr(ma(1, 0), 32'h31);
      lineCmd <= 3'h2;
      @(posedge clk);
      #1;
      lineCmd <= 3'h0;
      repeat (12) @(posedge clk);
      rd(`CACCW_FLAGS_ADDR, 32'h0);
      lineCmd <= 3'h1;
      w = 0;
      while (irq !== 1'b1 && w < 20) begin
         @(posedge clk);
         w++;
      end
      if (w >= 20) tmo();
      rd(ma(0, 4), {24'h0, r[7:0]});
      rd(ma(0, 8), {24'h0, r[15:8]});
      rd(`CACCW_FLAGS_ADDR, 32'h1);
      globalIrqEnable <= 0;
      repeat (2) @(posedge clk);
      chk(irq, 0);
      wr(ma(0, 0), 32'h00);
      wr(ma(1, 0), 32'h00);
      wr(`CACCW_FLAGS_ADDR, 32'h00);
      lineCmd <= 3'h0;
      $display("test capture done");
      r = rnd();
      wr(ma(1, 0), 32'h48);
      wr(ma(1, 4), {24'h0, r[7:0]});
      rd(ma(1, 0), 32'h08);
      wr(ma(1, 8), {24'h0, r[15:8]});
      rd(ma(1, 0), 32'h48);
      adv(r[15:0] + 16'h1);
      rd(`CACCW_FLAGS_ADDR, 32'h0);
      adv(r[15:0]);
      rd(`CACCW_FLAGS_ADDR, 32'h2);
      wr(ma(1, 0), 32'h00);
      $display("test timer done");
      wr(ma(0, 4), 32'h21);
      wr(ma(0, 8), 32'h43);
      wr(ma(0, 0), 32'h4c);
      for (int i = 0; i < 2; i++) begin
         adv(16'h4321);
         chk(ioOut[0], !i[0]);
      end
      wr(ma(0, 4), 32'h10);
      wr(ma(0, 8), 32'h20);
      wr(ma(0, 0), 32'h46);
      adv(16'h0010);
      chk(ioOut[0], 1);
      rd(ma(0, 4), 32'h30);
      adv(16'h0030);
      chk(ioOut[0], 0);
      $display("test toggle done");
      wr(ma(1, 4), 32'h80);
      wr(ma(1, 8), 32'h40);
      wr(ma(1, 0), 32'h42);
      adv(16'h0580);
      chk(ioOut[1], 1);
      adv(16'h0600);
      chk(ioOut[1], 0);
      rd(ma(1, 4), 32'h40);
      wr(ma(1, 4), 32'h40);
      adv(16'h0640);
      chk(ioOut[1], 0);
      wr(`CACCW_FLAGS_ADDR, 32'h00);
      wr(ma(0, 4), 32'h34);
      wr(ma(0, 8), 32'h12);
      wr(ma(0, 0), 32'hcb);
      adv(16'h1234);
      chk(ioOut[0], 1);
      rd(`CACCW_FLAGS_ADDR, 32'h1);
      adv(16'h0000);
      chk(ioOut[0], 0);
      $display("test pwm done");
      stop_test();
   end
endmodule
